// ---- apk_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - power functions run only when pins are not user GPIO and default drive
// - while host power is off, blank the display
// - power output is released until an action, then drives polarity level
// - reset output is released until a reset, then drives polarity level
// - the watchdog reset uses the same reset output and polarity
// - power on, hard off and hard reset each need their own enable
// - sense low and confirm held 0.25 s gives a configured power pulse
// - sense high and cancel held 4 s gives at least one power pulse
// - cancel still held after the pulse extends driving up to 5 more seconds
// - sense high and confirm held 4 s drives reset for 1 second
// - the block resets itself right after a host reset pulse
module apk_ctrl (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  input  wire logic [3:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata,
  input  wire logic                 host_sense,
  input  wire logic                 key_confirm,
  input  wire logic                 key_cancel,
  output logic                      pwr_ctl_o,
  output logic                      pwr_ctl_oe,
  output logic                      host_rst_o,
  output logic                      host_rst_oe,
  output logic                      display_blank,
  output logic                      self_reset
);

  apk_pkg::apk_state_s q_ff;
  apk_pkg::apk_state_s nxt_q;

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic pins_ok;
    logic sense;
    logic ok;
    logic x;
    logic wdog;
    pins_ok = 1'b0;
    sense   = 1'b0;
    ok      = 1'b0;
    x       = 1'b0;
    wdog    = 1'b0;
    nxt_q   = q_ff;
    // two-flop synchronisers on the pins; only s2 is read below
    nxt_q.s1.sense  = host_sense;
    nxt_q.s1.key_ok = key_confirm;
    nxt_q.s1.key_x  = key_cancel;
    nxt_q.s2        = q_ff.s1;
    sense = q_ff.s2.sense;
    ok    = q_ff.s2.key_ok;
    x     = q_ff.s2.key_x;
    nxt_q.self_rst = 1'b0;
    nxt_q.rdata    = 32'h0000_0000;

    // register writes
    if (wr) begin
      case (addr)
        apk_pkg::REG_CFG: nxt_q.cfg = wdata[6:0];
        apk_pkg::REG_PULSE: nxt_q.pw = wdata[apk_pkg::CNT_W-1:0];
        apk_pkg::REG_WDOG: wdog = wdata[apk_pkg::WDOG_BIT];
        default: ;
      endcase
    end
    // register reads, answered next cycle; unmapped reads give zero
    if (rd) begin
      case (addr)
        apk_pkg::REG_CFG: nxt_q.rdata = {25'h0, q_ff.cfg};
        apk_pkg::REG_PULSE: nxt_q.rdata = {5'h0, q_ff.pw};
        apk_pkg::REG_STATUS: nxt_q.rdata = {24'h0, q_ff.rst_oe, q_ff.pwr_oe,
          q_ff.blank, x, ok, sense, 2'h0} | {29'h0, q_ff.st};
        default: nxt_q.rdata = 32'h0000_0000;
      endcase
    end

    pins_ok = !q_ff.cfg[apk_pkg::CFG_PIN_USER]
            && !q_ff.cfg[apk_pkg::CFG_PIN_NODEF];
    // blank while host power is off
    nxt_q.blank = !sense;

    nxt_q.hold  = q_ff.hold + 27'h1;
    nxt_q.pulse = q_ff.pulse + 27'h1;
    case (q_ff.st)
      apk_pkg::APK_IDLE: begin
        // restart timer when no qualifying key is held
        if (!(ok || x) || !pins_ok)
          nxt_q.hold = '0;
        nxt_q.pulse = '0;
        if (wdog && pins_ok) begin
          nxt_q.st = apk_pkg::APK_RST;
        end else if (pins_ok && !sense && ok
            && q_ff.cfg[apk_pkg::CFG_EN_ON]
            && q_ff.hold >= 27'(apk_pkg::ON_HOLD_CYC - 1)) begin
          nxt_q.st = apk_pkg::APK_PWR_ON;
        end else if (pins_ok && sense && x
            && q_ff.cfg[apk_pkg::CFG_EN_OFF]
            && q_ff.hold >= 27'(apk_pkg::OFF_HOLD_CYC - 1)) begin
          nxt_q.st = apk_pkg::APK_PWR_OFF;
        end else if (pins_ok && sense && ok
            && q_ff.cfg[apk_pkg::CFG_EN_RST]
            && q_ff.hold >= 27'(apk_pkg::RST_HOLD_CYC - 1)) begin
          nxt_q.st = apk_pkg::APK_RST;
        end
        // each key action gated by its enable (above); the watchdog reset needs none
        if (nxt_q.st != apk_pkg::APK_IDLE)
          nxt_q.hold = '0;
      end
      apk_pkg::APK_PWR_ON: begin
        if (q_ff.pulse >= q_ff.pw - 27'h1) begin
          nxt_q.st = apk_pkg::APK_WAIT_REL;
        end
      end
      apk_pkg::APK_PWR_OFF: begin
        if (q_ff.pulse >= q_ff.pw - 27'h1) begin
          nxt_q.pulse = '0;
          nxt_q.st = x ? apk_pkg::APK_PWR_EXT : apk_pkg::APK_WAIT_REL;
        end
      end
      apk_pkg::APK_PWR_EXT: begin
        if (!x || q_ff.pulse >= 27'(apk_pkg::OFF_EXTRA_CYC - 1))
          nxt_q.st = apk_pkg::APK_WAIT_REL;
      end
      apk_pkg::APK_RST: begin
        if (q_ff.pulse >= 27'(apk_pkg::RST_PULSE_CYC - 1)) begin
          nxt_q.st = apk_pkg::APK_WAIT_REL;
          nxt_q.self_rst = 1'b1;
        end
      end
      apk_pkg::APK_WAIT_REL: begin
        nxt_q.pulse = '0;
        nxt_q.hold  = '0;
        if (!ok && !x)
          nxt_q.st = apk_pkg::APK_IDLE;
      end
      default: nxt_q.st = apk_pkg::APK_IDLE;
    endcase

    // power line driven only during a pulse or its extension, level per polarity
    nxt_q.pwr_oe = (nxt_q.st == apk_pkg::APK_PWR_ON)
                || (nxt_q.st == apk_pkg::APK_PWR_OFF)
                || (nxt_q.st == apk_pkg::APK_PWR_EXT);
    nxt_q.pwr_o  = nxt_q.pwr_oe & q_ff.cfg[apk_pkg::CFG_PWR_INV];
    // reset line driven only during reset, level per polarity
    nxt_q.rst_oe = (nxt_q.st == apk_pkg::APK_RST);
    nxt_q.rst_o  = nxt_q.rst_oe & q_ff.cfg[apk_pkg::CFG_RST_INV];

    // self reset parks the control state in APK_WAIT_REL and clears hold and pulse timers
    if (q_ff.self_rst) begin
      nxt_q.st    = apk_pkg::APK_WAIT_REL;
      nxt_q.hold  = '0;
      nxt_q.pulse = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      q_ff          <= '0;
      q_ff.st       <= apk_pkg::APK_IDLE;
      q_ff.cfg      <= apk_pkg::CFG_RESET;
      q_ff.pw       <= apk_pkg::PULSE_RESET[apk_pkg::CNT_W-1:0];
      q_ff.blank    <= 1'b1; // host assumed off until sensed
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign rdata         = q_ff.rdata;
  assign pwr_ctl_o     = q_ff.pwr_o;
  assign pwr_ctl_oe    = q_ff.pwr_oe;
  assign host_rst_o    = q_ff.rst_o;
  assign host_rst_oe   = q_ff.rst_oe;
  assign display_blank = q_ff.blank;
  assign self_reset    = q_ff.self_rst;

endmodule

`default_nettype wire

// ---- apk_pkg.sv ----
package apk_pkg;

  // clock rate and timing figures
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned ON_HOLD_MS      = 250;
  localparam int unsigned OFF_HOLD_MS     = 4000;
  localparam int unsigned RST_HOLD_MS     = 4000;
  localparam int unsigned RST_PULSE_MS    = 1000;
  localparam int unsigned PWR_PULSE_MS    = 1000;
  localparam int unsigned OFF_EXTRA_MS    = 5000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned ON_HOLD_CYC     = ON_HOLD_MS * CYC_PER_MS;
  localparam int unsigned OFF_HOLD_CYC    = OFF_HOLD_MS * CYC_PER_MS;
  localparam int unsigned RST_HOLD_CYC    = RST_HOLD_MS * CYC_PER_MS;
  localparam int unsigned RST_PULSE_CYC   = RST_PULSE_MS * CYC_PER_MS;
  localparam int unsigned PWR_PULSE_CYC   = PWR_PULSE_MS * CYC_PER_MS;
  localparam int unsigned OFF_EXTRA_CYC   = OFF_EXTRA_MS * CYC_PER_MS;
  localparam int unsigned CNT_W           = 27;

  // register map
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  REG_CFG         = 4'h0;
  localparam logic [3:0]  REG_PULSE       = 4'h4;
  localparam logic [3:0]  REG_STATUS      = 4'h8;
  localparam logic [3:0]  REG_WDOG        = 4'hC;

  // cfg register fields
  localparam int unsigned CFG_EN_ON       = 0;
  localparam int unsigned CFG_EN_OFF      = 1;
  localparam int unsigned CFG_EN_RST      = 2;
  localparam int unsigned CFG_PWR_INV     = 3;
  localparam int unsigned CFG_RST_INV     = 4;
  localparam int unsigned CFG_PIN_USER    = 5;
  localparam int unsigned CFG_PIN_NODEF   = 6;
  localparam logic [6:0]  CFG_RESET       = 7'h00;
  localparam logic [31:0] PULSE_RESET     = 32'h0098_9680;
  localparam logic [0:0]  WDOG_BIT        = 1'h0;

  typedef enum logic [2:0] {
    APK_IDLE, APK_PWR_ON, APK_PWR_OFF, APK_PWR_EXT, APK_RST, APK_WAIT_REL
  } apk_state_e;

  // synchronised host-side inputs
  typedef struct packed {
    logic sense;
    logic key_ok;
    logic key_x;
  } apk_in_s;

  // complete block state
  typedef struct packed {
    apk_state_e             st;
    logic [CNT_W-1:0]       hold;
    logic [CNT_W-1:0]       pulse;
    logic [6:0]             cfg;
    logic [CNT_W-1:0]       pw;
    apk_in_s                s1;
    apk_in_s                s2;
    logic                   pwr_oe;
    logic                   pwr_o;
    logic                   rst_oe;
    logic                   rst_o;
    logic                   blank;
    logic                   self_rst;
    logic [31:0]            rdata;
  } apk_state_s;

endpackage

// ---- apk_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// judges the key controller at its pins and register port only
module apk_chk (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [31:0] rdata,
  input  wire logic        host_sense,
  input  wire logic        pwr_ctl_o,
  input  wire logic        pwr_ctl_oe,
  input  wire logic        host_rst_o,
  input  wire logic        host_rst_oe,
  input  wire logic        display_blank,
  input  wire logic        self_reset
);
  logic [6:0] cfg_ff;
  logic       wd_go;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // shadow of the settings, so pin levels can be judged against them
  always_ff @(posedge mclk) begin
    if (srst)
      cfg_ff <= apk_pkg::CFG_RESET;
    else if (wr && addr == apk_pkg::REG_CFG)
      cfg_ff <= wdata[6:0];
  end
  // watchdog kick with reset enabled and pins in default use
  assign wd_go = wr && addr == apk_pkg::REG_WDOG
                 && wdata[apk_pkg::WDOG_BIT]
                 && cfg_ff[apk_pkg::CFG_EN_RST]
                 && !cfg_ff[apk_pkg::CFG_PIN_USER]
                 && !cfg_ff[apk_pkg::CFG_PIN_NODEF] && !host_rst_oe;
  ////////////////////////////////////////////////////////////////////////////
  blank_follow_a: assert property ($stable(host_sense)[*5] |->
    display_blank == !host_sense) else $error("blank wrong");
  pwr_level_a: assert property (pwr_ctl_oe |->
    pwr_ctl_o == cfg_ff[apk_pkg::CFG_PWR_INV]) else $error("power level");
  rst_level_a: assert property (host_rst_oe |->
    host_rst_o == cfg_ff[apk_pkg::CFG_RST_INV]) else $error("reset level");
  wdog_fire_a: assert property (wd_go |-> ##[1:8] host_rst_oe)
    else $error("watchdog reset missing");
  selfrst_one_a: assert property (self_reset |=> !self_reset)
    else $error("self reset too long");
  selfrst_cause_a: assert property (self_reset |->
    $past(host_rst_oe) || $past(host_rst_oe, 2)) else $error("stray self");
  rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not idle");
  cfg_read_a: assert property (rd && addr == apk_pkg::REG_CFG |=>
    rdata[6:0] == cfg_ff) else $error("config readback wrong");
  cover property ($rose(host_rst_oe));
  cover property ($fell(display_blank));
  cover property (rd ##1 rdata != 32'h0);
endmodule
bind apk_ctrl apk_chk u_apk_chk (.mclk(mclk), .srst(srst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .host_sense(host_sense),
  .pwr_ctl_o(pwr_ctl_o), .pwr_ctl_oe(pwr_ctl_oe), .host_rst_o(host_rst_o),
  .host_rst_oe(host_rst_oe), .display_blank(display_blank),
  .self_reset(self_reset));
`default_nettype wire

// ---- apk_mobo.sv ----
`timescale 1ns/100ps
`default_nettype none
// board switch inputs are pulled up: a released pin reads high
module apk_mobo (
  input  wire logic pwr_o,
  input  wire logic pwr_oe,
  input  wire logic rst_o,
  input  wire logic rst_oe,
  output logic      pwr_line,
  output logic      rst_line
);
  assign pwr_line = pwr_oe ? pwr_o : 1'b1;
  assign rst_line = rst_oe ? rst_o : 1'b1;
endmodule
`default_nettype wire

// ---- atx_power_key_control_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
module atx_power_key_control_bench;
  logic        mclk, srst, wr, rd, sense, kok, kx, p_o, p_oe, r_o, r_oe;
  logic        blank, self_rst, p_line, r_line;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, m_cfg, m_pw;
  int          error_cnt, n_checks, cyc;
  apk_ctrl u_apk_ctrl (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .host_sense(sense), .key_confirm(kok),
    .key_cancel(kx), .pwr_ctl_o(p_o), .pwr_ctl_oe(p_oe), .host_rst_o(r_o),
    .host_rst_oe(r_oe), .display_blank(blank), .self_reset(self_rst));
  apk_mobo u_apk_mobo (.pwr_o(p_o), .pwr_oe(p_oe), .rst_o(r_o),
    .rst_oe(r_oe), .pwr_line(p_line), .rst_line(r_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // one-cycle strobes; an idle edge between accesses avoids double drives
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    tick(1);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    tick(1);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // hang guard, far above the few thousand cycles the tests need
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial begin
    {srst, wr, rd, sense, kok, kx} = 6'h20;
    {addr, wdata, error_cnt, n_checks} = '0;
    void'($urandom(73742));
    tick(10);
    srst <= 1'b0;
    m_pw = apk_pkg::PULSE_RESET;
    acc(1'b0, apk_pkg::REG_PULSE, 0);
    chk("pulse", m_pw, rdata);
    chk("blank", 1, blank);
    chk("pwr_line", 1, p_line);
    for (int i = 0; i < 4; i++) begin
      m_cfg = $urandom & 32'h7F;
      acc(1'b1, apk_pkg::REG_CFG, m_cfg);
      acc(1'b1, 4'h2, $urandom);
      acc(1'b0, apk_pkg::REG_CFG, 0);
      chk("cfg", m_cfg, rdata);
      acc(1'b0, 4'h1, 0);
      chk("unmapped", 0, rdata);
    end
    $display("register test done");
    acc(1'b1, apk_pkg::REG_CFG, 32'h7);
    kok <= 1'b1;
    tick($urandom_range(3000, 100));
    kok <= 1'b0;
    sense <= 1'b1;
    tick(6);
    // look after the edge so the registered outputs have settled
    #1;
    chk("pwr_oe", 0, p_oe);
    chk("blank", 0, blank);
    $display("short press test done");
    for (int inv = 0; inv < 2; inv++) begin
      acc(1'b1, apk_pkg::REG_CFG, 32'h4 | (inv << 4));
      acc(1'b1, apk_pkg::REG_WDOG, 32'h1);
      for (int k = 0; k < 10 && r_oe !== 1'b1; k++)
        tick(1);
      #1 chk("rst_oe", 1, r_oe);
      chk("rst_line", inv, r_line);
      tick(1);
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      #1 chk("rst_line", 1, r_line);
    end
    $display("watchdog test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
